// ===== sfd_pkg.sv
// package for the start delimiter match block: register map, fields, resets
// assumes nothing beyond a synthesizable tool flow
package sfd_pkg;
  // register indexes (byte-wide registers on the plain register port)
  localparam logic [7:0] ADDR_NET_CFG    = 8'h00;
  localparam logic [7:0] ADDR_THIRD_CFG  = 8'h03;
  localparam logic [7:0] ADDR_PIN_DATA   = 8'h07;
  localparam logic [7:0] ADDR_DLM_LOW    = 8'h08;
  localparam logic [7:0] ADDR_DLM_CENTER = 8'h09;
  localparam logic [7:0] ADDR_DLM_HIGH   = 8'h0A;
  localparam logic [7:0] ADDR_AUX_INT    = 8'h0B;
  localparam logic [7:0] ADDR_AUX_UNMASK = 8'h0C;
  localparam logic [7:0] ADDR_PIN_CTRL   = 8'h1E;
  localparam logic [7:0] ADDR_CRC_OUT    = 8'h20;
  // reset values
  localparam logic [7:0] RST_DLM         = 8'h00;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [3:0] RST_AUX_INT     = 4'h4;
  // field positions
  localparam int NET_SEL_LO   = 0;
  localparam int THIRD_PRE_LO = 0;
  localparam int PIN_EDGE_LO  = 3;
  localparam int PIN_TXD_BIT  = 0;
  localparam int CTRL_FN_BIT  = 0;
  localparam int CTRL_EN_BIT  = 1;
  localparam int AUX_USER_BIT = 3;
  // delimiter select codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_8    = 2'h1;
  localparam logic [1:0] SEL_16   = 2'h2;
  localparam logic [1:0] SEL_24   = 2'h3;
  // fifo
  localparam int FIFO_WIDTH = 2;
  localparam int FIFO_DEPTH = 8;
  // preamble counter width (preamble setting counts bits)
  localparam int PRE_W = 8;
endpackage : sfd_pkg

// ===== sfd_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module sfd_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sfd_fifo
`default_nettype wire

// ===== sfd_match.sv
// serial delimiter comparator: shift register of recent bits and masked compare
// assumes one bit per valid strobe, first medium bit shifted in first
`timescale 1ns/100ps
`default_nettype none
module sfd_match
  import sfd_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // bit stream
  input  wire logic        i_start,
  input  wire logic        i_bit_valid,
  input  wire logic        i_bit,
  // configuration
  input  wire logic [23:0] i_pattern,
  input  wire logic [1:0]  i_sel,
  input  wire logic [7:0]  i_pre_len,
  // result
  output logic             o_crc_start
);
  // number of delimiter bits in use for a select code
  function automatic logic [4:0] sel_len(input logic [1:0] s);
    case (s)
      SEL_8:   sel_len = 5'd8;
      SEL_16:  sel_len = 5'd16;
      SEL_24:  sel_len = 5'd24;
      default: sel_len = 5'd0;
    endcase
  endfunction

  logic [23:0]      hist_q;
  logic [PRE_W-1:0] pre_q;
  logic             done_q;
  logic [4:0]       seen_q;
  wire  [4:0]       len      = sel_len(i_sel);
  wire  [23:0]      hist_d   = {i_bit, hist_q[23:1]};
  // after len bits the first bit sits at index 24-len; align pattern bit 0 there
  wire  [23:0]      aligned  = hist_d >> (5'd24 - len);
  wire  [23:0]      mask     = (len == 5'd0) ? 24'h000000 : (24'hFFFFFF >> (5'd24 - len));
  wire              pre_done = (pre_q >= i_pre_len);
  wire              dlm_hit  = ((aligned & mask) == (i_pattern & mask));
  wire              seen_ok  = ((seen_q + 5'd1) >= len);
  // delimiter search opens once the preamble length has passed
  wire              hit      = (len == 5'd0) ? pre_done : (pre_done && seen_ok && dlm_hit);

  always_ff @(posedge i_clk) begin
    if (i_rst || i_start) begin
      hist_q      <= '0;
      pre_q       <= '0;
      seen_q      <= '0;
      done_q      <= 1'b0;
      o_crc_start <= 1'b0;
    end else begin
      o_crc_start <= 1'b0;
      if (i_bit_valid && !done_q) begin
        hist_q <= hist_d;
        if (!pre_done) begin
          pre_q <= pre_q + 1'b1;
        end
        if (seen_q != 5'd31) begin
          seen_q <= seen_q + 5'd1;
        end
        if (hit) begin
          done_q      <= 1'b1;
          o_crc_start <= 1'b1;
        end
      end
    end
  end
endmodule : sfd_match
`default_nettype wire

// ===== sfd_top.sv
// start delimiter match top: registers, user pin events, tx pin override,
// an rx and a tx delimiter comparator, and a fifo of crc start events
// assumes pins are asynchronous and the register master never waits
//
// Overview of operation
// - three byte registers at 08h, 09h, 0Ah hold the 24-bit delimiter
// - all three delimiter bytes reset to zero
// - delimiter matching on receive and transmit streams marks crc start
// - two-bit select field picks none, part or all of the pattern
// - pattern bit 0 meets the first medium bit, higher bits follow
// - preamble length setting also affects where crc starts
// - writing one to an aux interrupt bit clears it
// - writing zero to an aux interrupt bit leaves it unchanged
// - pending unmasked aux interrupts raise the more-interrupts flag
// - reading the tx override bit returns the live tx data pin level
// - override drives tx pin only when function, enable and card strap high
// - user pin edge selected by two-bit field sets the user event flag
// - each aux unmask bit enables summary of the matching status bit
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module sfd_top
  import sfd_pkg::*;
(
  // clock and reset
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RST,
  // register port
  input  wire logic [7:0] i_ADDR,
  input  wire logic [7:0] i_WDATA,
  input  wire logic       i_WR,
  input  wire logic       i_RD,
  output logic [7:0]      o_RDATA,
  // aux interrupt sources from the rest of the transceiver interface
  input  wire logic [2:0] i_AUX_EVENT,
  // summary to the main interrupt register
  output logic            o_MORE_INT,
  // serial streams
  input  wire logic       i_RX_START,
  input  wire logic       i_RX_BIT_VALID,
  input  wire logic       i_RX_BIT,
  input  wire logic       i_TX_START,
  input  wire logic       i_TX_BIT_VALID,
  input  wire logic       i_TX_BIT,
  // crc start events, bit 0 receive, bit 1 transmit
  output logic            o_CRC_VALID,
  input  wire logic       i_CRC_READY,
  output logic [1:0]      o_CRC_START,
  // pins
  input  wire logic       i_USER_PIN,
  input  wire logic       i_CARD_MODE,
  input  wire logic       i_TXD_PIN,
  input  wire logic       i_TXD_CORE,
  output logic            o_TXD_PIN,
  output logic            o_TXD_OE
);
  import sfd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] dlm_low_q;
  logic [7:0] dlm_center_q;
  logic [7:0] dlm_high_q;
  logic [7:0] net_cfg_q;
  logic [7:0] third_cfg_q;
  logic [7:0] pin_data_q;
  logic [7:0] pin_ctrl_q;
  logic [3:0] aux_int_q;
  logic [3:0] aux_int_d;
  logic [3:0] aux_unmask_q;
  logic [7:0] rdata_q;

  function automatic logic wr_at(input logic [7:0] a, input logic [7:0] r, input logic w);
    wr_at = w && (a == r);
  endfunction

  wire we_low    = wr_at(i_ADDR, ADDR_DLM_LOW, i_WR);
  wire we_center = wr_at(i_ADDR, ADDR_DLM_CENTER, i_WR);
  wire we_high   = wr_at(i_ADDR, ADDR_DLM_HIGH, i_WR);
  wire we_net    = wr_at(i_ADDR, ADDR_NET_CFG, i_WR);
  wire we_third  = wr_at(i_ADDR, ADDR_THIRD_CFG, i_WR);
  wire we_pin    = wr_at(i_ADDR, ADDR_PIN_DATA, i_WR);
  wire we_ctrl   = wr_at(i_ADDR, ADDR_PIN_CTRL, i_WR);
  wire we_aux    = wr_at(i_ADDR, ADDR_AUX_INT, i_WR);
  wire we_unmask = wr_at(i_ADDR, ADDR_AUX_UNMASK, i_WR);

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      dlm_low_q    <= RST_DLM;
      dlm_center_q <= RST_DLM;
      dlm_high_q   <= RST_DLM;
      net_cfg_q    <= RST_ZERO;
      third_cfg_q  <= RST_ZERO;
      pin_data_q   <= RST_ZERO;
      pin_ctrl_q   <= RST_ZERO;
      aux_unmask_q <= 4'h0;
    end else begin
      if (we_low)    dlm_low_q    <= i_WDATA;
      if (we_center) dlm_center_q <= i_WDATA;
      if (we_high)   dlm_high_q   <= i_WDATA;
      if (we_net)    net_cfg_q    <= i_WDATA;
      if (we_third)  third_cfg_q  <= i_WDATA;
      if (we_pin)    pin_data_q   <= i_WDATA;
      if (we_ctrl)   pin_ctrl_q   <= i_WDATA;
      if (we_unmask) aux_unmask_q <= i_WDATA[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and user pin edge detection
  logic [1:0] user_sync_q;
  logic [1:0] txd_sync_q;
  logic [1:0] card_sync_q;
  logic       user_prev_q;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      user_sync_q <= 2'h0;
      txd_sync_q  <= 2'h0;
      card_sync_q <= 2'h0;
      user_prev_q <= 1'b0;
    end else begin
      user_sync_q <= {user_sync_q[0], i_USER_PIN};
      txd_sync_q  <= {txd_sync_q[0], i_TXD_PIN};
      card_sync_q <= {card_sync_q[0], i_CARD_MODE};
      user_prev_q <= user_sync_q[1];
    end
  end

  wire [1:0] edge_sel  = pin_data_q[PIN_EDGE_LO +: 2];
  wire       rise      = user_sync_q[1] && !user_prev_q;
  wire       fall      = !user_sync_q[1] && user_prev_q;
  wire       user_evt  = (edge_sel[0] && rise) || (edge_sel[1] && fall);

  ////////////////////////////////////////////////////////////////////////////
  // aux interrupt status, write one to clear, a new event wins over the clear
  wire [3:0] aux_set   = {user_evt, i_AUX_EVENT};
  wire [3:0] aux_clr   = we_aux ? i_WDATA[3:0] : 4'h0;

  always_comb begin
    aux_int_d = (aux_int_q & ~aux_clr) | aux_set;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      aux_int_q <= RST_AUX_INT;
    end else begin
      aux_int_q <= aux_int_d;
    end
  end

  assign o_MORE_INT = |(aux_int_q & aux_unmask_q);

  ////////////////////////////////////////////////////////////////////////////
  // tx data pin override
  wire ovr_on = pin_ctrl_q[CTRL_FN_BIT] && pin_ctrl_q[CTRL_EN_BIT] && card_sync_q[1];
  logic txd_q;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      txd_q <= 1'b0;
    end else begin
      txd_q <= ovr_on ? pin_data_q[PIN_TXD_BIT] : i_TXD_CORE;
    end
  end
  assign o_TXD_PIN = txd_q;
  assign o_TXD_OE  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // delimiter comparators
  wire [23:0] pattern = {dlm_high_q, dlm_center_q, dlm_low_q};
  wire [1:0]  sel     = net_cfg_q[NET_SEL_LO +: 2];
  wire [7:0]  pre_len = third_cfg_q[THIRD_PRE_LO +: 8];
  wire        rx_hit;
  wire        tx_hit;

  sfd_match u_rx (
    .i_clk       (I_CLK_SYS),
    .i_rst       (I_RST),
    .i_start     (i_RX_START),
    .i_bit_valid (i_RX_BIT_VALID),
    .i_bit       (i_RX_BIT),
    .i_pattern   (pattern),
    .i_sel       (sel),
    .i_pre_len   (pre_len),
    .o_crc_start (rx_hit)
  );

  sfd_match u_tx (
    .i_clk       (I_CLK_SYS),
    .i_rst       (I_RST),
    .i_start     (i_TX_START),
    .i_bit_valid (i_TX_BIT_VALID),
    .i_bit       (i_TX_BIT),
    .i_pattern   (pattern),
    .i_sel       (sel),
    .i_pre_len   (pre_len),
    .o_crc_start (tx_hit)
  );

  // events queue so a stalled crc engine loses none of the first 8; a full fifo drops the event
  wire fifo_in_ready;
  wire fifo_in_valid = rx_hit || tx_hit;

  sfd_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_CLK_SYS),
    .i_rst       (I_RST),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   ({tx_hit, rx_hit}),
    .o_out_valid (o_CRC_VALID),
    .i_out_ready (i_CRC_READY),
    .o_out_data  (o_CRC_START)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe
  logic [7:0] rd_mux;
  always_comb begin
    case (i_ADDR)
      ADDR_DLM_LOW:    rd_mux = dlm_low_q;
      ADDR_DLM_CENTER: rd_mux = dlm_center_q;
      ADDR_DLM_HIGH:   rd_mux = dlm_high_q;
      ADDR_NET_CFG:    rd_mux = net_cfg_q;
      ADDR_THIRD_CFG:  rd_mux = third_cfg_q;
      ADDR_PIN_DATA:   rd_mux = {pin_data_q[7:1], txd_sync_q[1]};
      ADDR_PIN_CTRL:   rd_mux = pin_ctrl_q;
      ADDR_AUX_INT:    rd_mux = {4'h0, aux_int_q};
      ADDR_AUX_UNMASK: rd_mux = {4'h0, aux_unmask_q};
      ADDR_CRC_OUT:    rd_mux = {5'h00, fifo_in_ready, o_CRC_START};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= i_RD ? rd_mux : 8'h00;
    end
  end
  assign o_RDATA = rdata_q;
endmodule : sfd_top
`default_nettype wire

// ===== sfd_sva.sv
// checker for the start delimiter match top: register port, summary flag, events, tx pin
// assumes it is bound to sfd_top and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module sfd_sva
  import sfd_pkg::*;
(
  // clock and reset
  input wire logic       I_CLK_SYS,
  input wire logic       I_RST,
  // register port
  input wire logic [7:0] i_ADDR,
  input wire logic [7:0] i_WDATA,
  input wire logic       i_WR,
  input wire logic       i_RD,
  input wire logic [7:0] o_RDATA,
  // summary and events
  input wire logic [2:0] i_AUX_EVENT,
  input wire logic       o_MORE_INT,
  input wire logic       o_CRC_VALID,
  input wire logic       i_CRC_READY,
  input wire logic [1:0] o_CRC_START,
  // tx pin
  input wire logic       i_CARD_MODE,
  input wire logic       i_TXD_CORE,
  input wire logic       o_TXD_PIN
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the unmask bits fed by event inputs; bit 3 is left out since
  // the user pin path has a synchroniser whose delay is not pinned down here
  logic [2:0] umask_q;
  logic       wr_umask;
  assign wr_umask = i_WR && i_ADDR == ADDR_AUX_UNMASK;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) umask_q <= 3'h0;
    else if (wr_umask) umask_q <= i_WDATA[2:0];
  end
  sequence s_wr_low;
    i_WR && i_ADDR == ADDR_DLM_LOW;
  endsequence
  sequence s_rd_low;
    i_RD && i_ADDR == ADDR_DLM_LOW && !$past(i_WR);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_dlm_readback: assert property (s_wr_low ##2 s_rd_low |=> o_RDATA == $past(i_WDATA, 3))
    else $error("delimiter low byte readback mismatch");
  a_rdata_idle: assert property (!i_RD |=> o_RDATA == 8'h00)
    else $error("read data not zero outside a read answer");
  a_rd_unmapped: assert property (i_RD && i_ADDR == 8'h55 |=> o_RDATA == 8'h00)
    else $error("unmapped read returned data");
  a_w1c_clear: assert property (i_WR && i_ADDR == ADDR_AUX_INT && i_WDATA[3:0] == 4'hF
    && i_AUX_EVENT == 3'h0 |=> !o_MORE_INT) else $error("write one did not clear status");
  a_zero_keep: assert property (o_MORE_INT && i_WR && i_ADDR == ADDR_AUX_INT
    && i_WDATA == 8'h00 |=> o_MORE_INT) else $error("write zero changed status");
  a_event_flag: assert property (|(i_AUX_EVENT & umask_q) && !wr_umask |=> o_MORE_INT)
    else $error("unmasked event not summarised");
  a_unmask_off: assert property (wr_umask && i_WDATA == 8'h00 |=> !o_MORE_INT)
    else $error("summary raised with all bits masked");
  a_event_hold: assert property (o_CRC_VALID && !i_CRC_READY |=> o_CRC_VALID && $stable(o_CRC_START))
    else $error("crc start event lost before pop");
  a_core_path: assert property (!i_CARD_MODE [*5] |=> o_TXD_PIN == $past(i_TXD_CORE))
    else $error("tx pin overridden without card strap");
endmodule : sfd_sva
`default_nettype wire

// ===== sfd_phy_model.sv
// transceiver bit stream model: start pulse, then n bits of a word, bit 0 first
// assumes one go pulse per frame; slow mode leaves a gap cycle between bits
`timescale 1ns/100ps
`default_nettype none
module sfd_phy_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // frame command
  input  wire logic        i_go,
  input  wire logic        i_slow,
  input  wire logic [31:0] i_word,
  input  wire logic [5:0]  i_nbits,
  // stream
  output logic             o_start,
  output logic             o_valid,
  output logic             o_bit,
  output logic             o_busy
);
  logic [5:0]  left_q;
  logic [31:0] sh_q;
  logic        gap_q;
  assign o_busy = left_q != 6'h00 || o_start;
  always_ff @(posedge i_clk) begin
    o_start <= i_go && !i_rst;
    o_valid <= 1'b0;
    gap_q   <= i_slow && !gap_q;
    if (i_rst) begin
      left_q <= 6'h00;
      o_bit  <= 1'b0;
    end else if (i_go) begin
      left_q <= i_nbits;
      sh_q   <= i_word;
    end else if (left_q != 6'h00 && !o_start && !gap_q) begin
      o_valid <= 1'b1;
      o_bit   <= sh_q[0];
      sh_q    <= sh_q >> 1;
      left_q  <= left_q - 6'h01;
    end else begin
      // idle bit toggles so a stale value is never mistaken for data
      o_bit <= !o_bit;
    end
  end
endmodule : sfd_phy_model
`default_nettype wire

// ===== tb_sfd_top.sv
// testbench for sfd_top: register tasks, aux status, pins, delimiter streams, fifo
// assumes sfd_phy_model drives both streams and sfd_sva is bound below
`timescale 1ns/100ps
`default_nettype none
module tb_sfd_top;
  import sfd_pkg::*;
  logic I_CLK_SYS, I_RST, i_WR, i_RD, i_CRC_READY, i_USER_PIN, i_CARD_MODE, i_TXD_PIN, i_TXD_CORE;
  logic [7:0] i_ADDR, i_WDATA, v;
  logic [2:0] i_AUX_EVENT;
  logic [1:0] go;
  logic slow;
  logic [31:0] word;
  logic [5:0] nbits;
  logic [23:0] pat = 24'h9E3A1B;
  wire logic [7:0] o_RDATA;
  wire logic [1:0] o_CRC_START;
  wire logic o_MORE_INT, o_CRC_VALID, o_TXD_PIN, o_TXD_OE, rx_busy, tx_busy;
  wire logic i_RX_START, i_RX_BIT_VALID, i_RX_BIT, i_TX_START, i_TX_BIT_VALID, i_TX_BIT;
  int failures, check_count;
  sfd_top sfd_top_inst (.I_CLK_SYS, .I_RST, .i_ADDR, .i_WDATA, .i_WR, .i_RD, .o_RDATA,
    .i_AUX_EVENT, .o_MORE_INT, .i_RX_START, .i_RX_BIT_VALID, .i_RX_BIT, .i_TX_START,
    .i_TX_BIT_VALID, .i_TX_BIT, .o_CRC_VALID, .i_CRC_READY, .o_CRC_START, .i_USER_PIN,
    .i_CARD_MODE, .i_TXD_PIN, .i_TXD_CORE, .o_TXD_PIN, .o_TXD_OE);
  sfd_phy_model rx_phy (.i_clk(I_CLK_SYS), .i_rst(I_RST), .i_go(go[0]), .i_slow(slow),
    .i_word(word), .i_nbits(nbits), .o_start(i_RX_START), .o_valid(i_RX_BIT_VALID),
    .o_bit(i_RX_BIT), .o_busy(rx_busy));
  sfd_phy_model tx_phy (.i_clk(I_CLK_SYS), .i_rst(I_RST), .i_go(go[1]), .i_slow(slow),
    .i_word(word), .i_nbits(nbits), .o_start(i_TX_START), .o_valid(i_TX_BIT_VALID),
    .o_bit(i_TX_BIT), .o_busy(tx_busy));
  initial begin
    I_CLK_SYS = 1'b0;
    forever #5 I_CLK_SYS = ~I_CLK_SYS;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge I_CLK_SYS);
    i_WR <= 1'b1;
    i_ADDR <= a;
    i_WDATA <= d;
    @(posedge I_CLK_SYS);
    i_WR <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge I_CLK_SYS);
    i_RD <= 1'b1;
    i_ADDR <= a;
    @(posedge I_CLK_SYS);
    i_RD <= 1'b0;
    #1 v = o_RDATA;
  endtask : rd
  // one frame on receive (0) or transmit (1), then let the event reach the fifo
  task automatic send(input int ch, input logic [31:0] w, input int n);
    @(posedge I_CLK_SYS);
    go[ch] <= 1'b1;
    word <= w;
    nbits <= 6'(n);
    @(posedge I_CLK_SYS);
    go <= 2'b00;
    #1;
    for (int k = 0; k < 100 && (rx_busy || tx_busy); k++) @(posedge I_CLK_SYS);
    repeat (3) @(posedge I_CLK_SYS);
  endtask : send
  // expect event kind e at the fifo head and pop it; e of zero expects none
  task automatic pop(input logic [1:0] e);
    #1 chk({7'h0, o_CRC_VALID}, {7'h0, e != 2'b00}, "event present");
    if (e != 2'b00) begin
      chk({6'h0, o_CRC_START}, {6'h0, e}, "event kind");
      @(posedge I_CLK_SYS);
      i_CRC_READY <= 1'b1;
      @(posedge I_CLK_SYS);
      i_CRC_READY <= 1'b0;
    end
  endtask : pop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_WR, i_RD, i_CRC_READY, i_USER_PIN, i_CARD_MODE, i_TXD_PIN, i_TXD_CORE, slow} = '0;
    {i_ADDR, i_WDATA, i_AUX_EVENT, go, word, nbits} = '0;
    I_RST = 1'b1;
    repeat (8) @(posedge I_CLK_SYS);
    I_RST <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      rd(ADDR_DLM_LOW + 8'(k));
      chk(v, RST_DLM, "delimiter reset");
      wr(ADDR_DLM_LOW + 8'(k), pat[k*8+:8]);
      rd(ADDR_DLM_LOW + 8'(k));
      chk(v, pat[k*8+:8], "delimiter readback");
    end
    rd(8'h55);
    chk(v, 8'h00, "unmapped read");
    wr(ADDR_AUX_UNMASK, 8'h04);
    chk({7'h0, o_MORE_INT}, 8'h01, "reset status summarised");
    wr(ADDR_AUX_INT, 8'h00);
    chk({7'h0, o_MORE_INT}, 8'h01, "write zero keeps");
    wr(ADDR_AUX_INT, 8'h04);
    chk({7'h0, o_MORE_INT}, 8'h00, "write one clears");
    @(posedge I_CLK_SYS);
    i_AUX_EVENT <= 3'h2;
    @(posedge I_CLK_SYS);
    i_AUX_EVENT <= 3'h0;
    #1 chk({7'h0, o_MORE_INT}, 8'h00, "masked event silent");
    wr(ADDR_AUX_UNMASK, 8'h02);
    chk({7'h0, o_MORE_INT}, 8'h01, "unmasked event");
    wr(ADDR_AUX_UNMASK, 8'h00);
    chk({7'h0, o_MORE_INT}, 8'h00, "all masked");
    wr(ADDR_AUX_UNMASK, 8'h0F);
    wr(ADDR_AUX_INT, 8'h0F);
    chk({7'h0, o_MORE_INT}, 8'h00, "clear all");
    // a fresh event while unmasked must raise the summary from low
    @(posedge I_CLK_SYS);
    i_AUX_EVENT <= 3'h1;
    @(posedge I_CLK_SYS);
    i_AUX_EVENT <= 3'h0;
    #1 chk({7'h0, o_MORE_INT}, 8'h01, "unmasked pulse summarised");
    wr(ADDR_AUX_INT, 8'h01);
    chk({7'h0, o_MORE_INT}, 8'h00, "pulse cleared");
    wr(ADDR_AUX_UNMASK, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_PIN_DATA, 8'(c << PIN_EDGE_LO));
      for (int e = 0; e < 2; e++) begin
        // first pass raises the pin, second lowers it
        i_USER_PIN <= ~i_USER_PIN;
        repeat (6) @(posedge I_CLK_SYS);
        rd(ADDR_AUX_INT);
        chk(v & 8'h08, (e == 0 ? c % 2 : c / 2) != 0 ? 8'h08 : 8'h00, "user edge");
        wr(ADDR_AUX_INT, 8'h08);
      end
    end
    // override fully enabled but strap low: the core level must reach the pin
    wr(ADDR_PIN_CTRL, 8'h03);
    i_TXD_CORE <= 1'b1;
    repeat (5) @(posedge I_CLK_SYS);
    #1 chk({7'h0, o_TXD_PIN}, 8'h01, "strap low keeps core");
    chk({7'h0, o_TXD_OE}, 8'h01, "pin driven");
    i_CARD_MODE <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_PIN_DATA, 8'(k));
      i_TXD_PIN <= (k == 0);
      repeat (5) @(posedge I_CLK_SYS);
      #1 chk({7'h0, o_TXD_PIN}, 8'(k), "override drive");
      rd(ADDR_PIN_DATA);
      chk(v & 8'h01, 8'(k == 0), "live pin read");
    end
    wr(ADDR_PIN_CTRL, 8'h01);
    i_TXD_CORE <= 1'b0;
    repeat (3) @(posedge I_CLK_SYS);
    #1 chk({7'h0, o_TXD_PIN}, 8'h00, "override needs enable");
    for (int s = 1; s < 4; s++) begin
      wr(ADDR_NET_CFG, 8'(s));
      for (int ch = 0; ch < 2; ch++) begin
        send(ch, {8'h00, pat}, 8 * s);
        pop(2'(1 << ch));
        send(ch, {8'h00, pat} ^ (32'h1 << (8 * s - 1)), 8 * s);
        pop(2'b00);
      end
    end
    wr(ADDR_NET_CFG, 8'h01);
    wr(ADDR_THIRD_CFG, 8'h03);
    send(0, {21'h0, pat[7:0], 3'b010}, 11);
    pop(2'b01);
    wr(ADDR_THIRD_CFG, 8'h0C);
    send(0, {24'h0, pat[7:0]}, 8);
    pop(2'b00);
    wr(ADDR_NET_CFG, 8'h00);
    wr(ADDR_THIRD_CFG, 8'h04);
    slow = 1'b1;
    send(1, 32'h0, 6);
    pop(2'b10);
    slow = 1'b0;
    wr(ADDR_THIRD_CFG, 8'h00);
    for (int k = 0; k < 9; k++) send(0, 32'h0, 1);
    for (int k = 0; k < 9; k++) pop(k < 8 ? 2'b01 : 2'b00);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge I_CLK_SYS);
    failures++;
    print_verdict();
  end
endmodule : tb_sfd_top
bind sfd_top sfd_sva sfd_sva_inst (.I_CLK_SYS, .I_RST, .i_ADDR, .i_WDATA, .i_WR, .i_RD,
  .o_RDATA, .i_AUX_EVENT, .o_MORE_INT, .o_CRC_VALID, .i_CRC_READY, .o_CRC_START,
  .i_CARD_MODE, .i_TXD_CORE, .o_TXD_PIN);
`default_nettype wire
